// [core/plm_lane_pol.sv]
`default_nettype none
module plm_lane_pol (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic training,
	input wire plm_pkg::plm_rx_sym_t rx,
	output logic inv_q,
	output logic [7:0] data_q
);
	logic training_q;
	logic in_window;
	logic seen_inv;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			training_q <= 1'b0;
		end else begin
			training_q <= training;
		end
	end

	assign in_window = rx.idx >= plm_pkg::POL_SYM_FIRST &&
		rx.idx <= plm_pkg::POL_SYM_LAST;
	assign seen_inv = training && rx.ts_valid && in_window &&
		(rx.sym == plm_pkg::TS1_ID_INV || rx.sym == plm_pkg::TS2_ID_INV);

	// RULE_24 held until retraining
	always_ff @(posedge core_clk) begin
		if (srst) begin
			inv_q <= 1'b0;
		end else if (seen_inv) begin
			// RULE_01 detect inverted lane
			inv_q <= 1'b1;
		end else if (training && !training_q) begin
			inv_q <= 1'b0;
		end
	end

	// RULE_03 per-lane correction
	always_ff @(posedge core_clk) begin
		if (srst) begin
			data_q <= 8'h00;
		end else begin
			data_q <= rx.sym ^ {8{inv_q}};
		end
	end
endmodule : plm_lane_pol
`default_nettype wire

// [core/plm_pkg.sv]
`default_nettype none
package plm_pkg;
	localparam int LANES = 8;
	localparam int GROUP = 4;
	// Register offsets
	localparam logic [7:0] REG_SWITCH_CTRL = 8'h00;
	localparam logic [7:0] REG_LINK_CAP = 8'h04;
	localparam logic [7:0] REG_LINK_CTRL = 8'h08;
	localparam logic [7:0] REG_LINK_STATUS = 8'h0C;
	localparam logic [7:0] REG_DEV_CAP = 8'h10;
	localparam logic [7:0] REG_SLOT_CAP = 8'h14;
	localparam logic [7:0] REG_PM_CTRL = 8'h18;
	// Field positions
	localparam int UNLOCK_BIT = 0;
	localparam int MAXW_LSB = 0;
	localparam int RETRAIN_BIT = 5;
	localparam int LW_LSB = 4;
	localparam int SCALE_LSB = 18;
	localparam int VALUE_LSB = 26;
	localparam int DSTATE_LSB = 0;
	localparam logic [1:0] D3HOT = 2'h3;
	// Reset values
	localparam logic [5:0] MAXW_RST_X4 = 6'h04;
	localparam logic [5:0] MAXW_RST_X8 = 6'h08;
	localparam logic [31:0] SLOT_CAP_RST = 32'h0000_0000;
	// Training symbol window and inverted identifier symbols
	localparam logic [4:0] POL_SYM_FIRST = 5'h06;
	localparam logic [4:0] POL_SYM_LAST = 5'h10;
	localparam logic [7:0] TS1_ID_INV = 8'hB5;
	localparam logic [7:0] TS2_ID_INV = 8'hBA;

	typedef enum logic [3:0] {
		LT_DETECT = 4'h0, LT_POLLING = 4'h1, LT_CONFIG = 4'h2,
		LT_DISABLED = 4'h3, LT_LOOPBACK = 4'h4, LT_HOTRESET = 4'h5,
		LT_L0 = 4'h6, LT_L0S = 4'h7, LT_L1 = 4'h8, LT_L2 = 4'h9,
		LT_RECOVERY = 4'hA
	} plm_ltssm_t;

	typedef enum logic [2:0] {
		LS_DOWN = 3'b000, LS_L0 = 3'b001, LS_L0S = 3'b011,
		LS_L1 = 3'b010, LS_L23 = 3'b110
	} plm_lstate_t;

	typedef struct packed {
		logic ts_valid;
		logic [4:0] idx;
		logic [7:0] sym;
	} plm_rx_sym_t;

	typedef struct packed {
		logic [7:0] scale;
		logic [1:0] value;
	} plm_spl_t;
endpackage : plm_pkg
`default_nettype wire

// [core/plm_port.sv]
// The plain strobed port and the address map were left to the implementer.
`default_nettype none
// How it works
// RULE_01: Lanes scan training symbols 6..16 and invert data on inversion.
// RULE_02: Transmit data is never inverted; only receivers correct polarity.
// RULE_03: Each lane decides and applies inversion on its own.
// RULE_04: Merged port trains to 8/4/2/1 lanes, unmerged to 4/2/1.
// RULE_05: Negotiated width appears in the link status register.
// RULE_06: Max width field is writable only while unlock bit is set.
// RULE_07: Max width field holds the lane count directly: 2, 4 or 8.
// RULE_08: A new max width applies only at the next training.
// RULE_09: Narrow merged port powers down idle group, parks idle lanes in L1.
// RULE_10: Narrow unmerged port parks idle lanes in L1.
// RULE_11: A disabled port powers down all its lanes.
// RULE_12: Automatic lane reversal mapping follows configured max width.
// RULE_13: Upstream retrain write forces Recovery only while unlocked.
// RULE_14: Downstream retrain write forces Recovery regardless of unlock.
// RULE_15: On link down drop queued packets, flag targeted ones unsupported.
// RULE_16: Bridge config accesses still complete while downstream link down.
// RULE_17: On link up advertise credits sized from ingress queue sizes.
// RULE_18: Upstream captures slot power message scale and value fields.
// RULE_19: Downstream sends slot power message on slot cap write while up.
// RULE_20: Downstream sends slot power message when link comes up.
// RULE_21: L2/L3 ready follows turn-off acknowledge; no packets in it.
// RULE_22: L1 entered automatically or when function is placed in D3hot.
// RULE_23: Detect through Hot-Reset training states count as link down.
// RULE_24: Lane inversion holds until retraining, cleared by reset.
module plm_port #(
	parameter bit IS_UPSTREAM = 1'b0,
	parameter logic [7:0] FC_HDR_CREDITS = 8'h10,
	parameter logic [11:0] FC_DATA_CREDITS = 12'h080
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_q,
	input wire plm_pkg::plm_ltssm_t ltssm_state,
	input wire logic merged,
	input wire logic port_en,
	input wire logic [3:0] partner_width,
	input wire logic rev_detect,
	input wire plm_pkg::plm_rx_sym_t [7:0] lane_rx,
	input wire logic [7:0] tx_data_in,
	input wire logic aspm_l1_req,
	input wire logic pme_turnoff_ack,
	input wire logic spl_rx_valid,
	input wire plm_pkg::plm_spl_t spl_rx,
	output logic [7:0] rx_inv_q,
	output logic [7:0][7:0] rx_data_q,
	output logic [7:0] tx_data_q,
	output logic [5:0] width_q,
	output logic [7:0] lane_pd_q,
	output logic [7:0] lane_l1_q,
	output logic [7:0][2:0] lane_map_q,
	output logic retrain_q,
	output logic link_up_q,
	output plm_pkg::plm_lstate_t lstate_q,
	output logic discard_q,
	output logic ur_mode_q,
	output logic bridge_cfg_ok_q,
	output logic fc_adv_q,
	output logic [7:0] fc_hdr_q,
	output logic [11:0] fc_data_q,
	output logic spl_send_q,
	output plm_pkg::plm_spl_t spl_tx_q,
	output logic l1_req_q,
	output logic tlp_block_q
);
	logic unlock_q;
	logic [5:0] maxw_q;
	logic [1:0] dstate_q;
	plm_pkg::plm_spl_t cap_q;
	logic [31:0] slot_cap_q;
	logic training;
	logic training_q;
	logic down_now;
	logic train_done;
	logic wr_maxw;
	logic wr_retrain;
	logic wr_slot;
	logic went_up;
	logic went_down;
	plm_pkg::plm_lstate_t lstate_d;

	function automatic logic is_link_down(input plm_pkg::plm_ltssm_t s);
		case (s)
			plm_pkg::LT_DETECT, plm_pkg::LT_POLLING, plm_pkg::LT_CONFIG,
			plm_pkg::LT_DISABLED, plm_pkg::LT_LOOPBACK,
			plm_pkg::LT_HOTRESET: is_link_down = 1'b1;
			default: is_link_down = 1'b0;
		endcase
	endfunction : is_link_down

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = a == off;
	endfunction : hit

	// RULE_23 training states are link down
	assign down_now = is_link_down(ltssm_state);
	assign training = is_link_down(ltssm_state);
	assign train_done = training_q && !training;
	assign went_up = !down_now && !link_up_q;
	assign went_down = down_now && link_up_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			training_q <= 1'b0;
		end else begin
			training_q <= training;
		end
	end

	genvar g;
	generate
		for (g = 0; g < plm_pkg::LANES; g++) begin : g_lane
			plm_lane_pol u_pol (
				.core_clk(core_clk),
				.srst(srst),
				.training(training),
				.rx(lane_rx[g]),
				.inv_q(rx_inv_q[g]),
				.data_q(rx_data_q[g])
			);
		end
	endgenerate

	// RULE_02 transmit path untouched
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_data_q <= 8'h00;
		end else begin
			tx_data_q <= tx_data_in;
		end
	end

	plm_width_ctl u_width (
		.core_clk(core_clk),
		.srst(srst),
		.merged(merged),
		.port_en(port_en),
		.train_start(training && !training_q),
		.train_done(train_done),
		.partner_width(partner_width),
		.rev_detect(rev_detect),
		.maxw_field(maxw_q),
		.width_q(width_q),
		.lane_pd_q(lane_pd_q),
		.lane_l1_q(lane_l1_q),
		.lane_map_q(lane_map_q)
	);

	assign wr_maxw = reg_wr && hit(reg_addr, plm_pkg::REG_LINK_CAP);
	assign wr_retrain = reg_wr && hit(reg_addr, plm_pkg::REG_LINK_CTRL) &&
		reg_wdata[plm_pkg::RETRAIN_BIT];
	assign wr_slot = reg_wr && hit(reg_addr, plm_pkg::REG_SLOT_CAP);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			unlock_q <= 1'b0;
			dstate_q <= 2'h0;
			slot_cap_q <= plm_pkg::SLOT_CAP_RST;
		end else if (reg_wr) begin
			if (hit(reg_addr, plm_pkg::REG_SWITCH_CTRL)) begin
				unlock_q <= reg_wdata[plm_pkg::UNLOCK_BIT];
			end
			if (hit(reg_addr, plm_pkg::REG_PM_CTRL)) begin
				dstate_q <= reg_wdata[plm_pkg::DSTATE_LSB +: 2];
			end
			if (wr_slot) begin
				slot_cap_q <= reg_wdata;
			end
		end
	end

	// RULE_06 RULE_07 locked lane-count field
	always_ff @(posedge core_clk) begin
		if (srst) begin
			maxw_q <= merged ? plm_pkg::MAXW_RST_X8 : plm_pkg::MAXW_RST_X4;
		end else if (wr_maxw && unlock_q) begin
			maxw_q <= reg_wdata[plm_pkg::MAXW_LSB +: 6];
		end
	end

	// RULE_13 RULE_14 retrain into Recovery
	always_ff @(posedge core_clk) begin
		if (srst) begin
			retrain_q <= 1'b0;
		end else begin
			retrain_q <= wr_retrain && (!IS_UPSTREAM || unlock_q);
		end
	end

	// RULE_15 link down handling
	always_ff @(posedge core_clk) begin
		if (srst) begin
			link_up_q <= 1'b0;
			discard_q <= 1'b0;
			ur_mode_q <= 1'b1;
		end else begin
			link_up_q <= !down_now;
			discard_q <= went_down;
			ur_mode_q <= down_now;
		end
	end

	// RULE_16 bridge config stays reachable
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bridge_cfg_ok_q <= 1'b0;
		end else begin
			bridge_cfg_ok_q <= !IS_UPSTREAM || !down_now;
		end
	end

	// RULE_17 credit advertisement
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fc_adv_q <= 1'b0;
			fc_hdr_q <= 8'h00;
			fc_data_q <= 12'h000;
		end else begin
			fc_adv_q <= went_up;
			if (went_up) begin
				fc_hdr_q <= FC_HDR_CREDITS;
				fc_data_q <= FC_DATA_CREDITS;
			end
		end
	end

	// RULE_18 capture slot power limit
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cap_q <= '0;
		end else if (IS_UPSTREAM && spl_rx_valid) begin
			cap_q <= spl_rx;
		end
	end

	// RULE_19 RULE_20 send slot power limit
	always_ff @(posedge core_clk) begin
		if (srst) begin
			spl_send_q <= 1'b0;
			spl_tx_q <= '0;
		end else begin
			spl_send_q <= !IS_UPSTREAM && ((wr_slot && link_up_q &&
				!down_now) || went_up);
			spl_tx_q.scale <= wr_slot ?
				reg_wdata[plm_pkg::SCALE_LSB +: 8] :
				slot_cap_q[plm_pkg::SCALE_LSB +: 8];
			spl_tx_q.value <= wr_slot ?
				reg_wdata[plm_pkg::VALUE_LSB +: 2] :
				slot_cap_q[plm_pkg::VALUE_LSB +: 2];
		end
	end

	// RULE_22 L1 from ASPM or D3hot
	always_ff @(posedge core_clk) begin
		if (srst) begin
			l1_req_q <= 1'b0;
		end else begin
			l1_req_q <= !down_now && lstate_q != plm_pkg::LS_L23 &&
				(aspm_l1_req || dstate_q == plm_pkg::D3HOT);
		end
	end

	// RULE_21 L2/L3 ready after acknowledge
	always_comb begin
		lstate_d = lstate_q;
		case (lstate_q)
			plm_pkg::LS_L23: begin
				if (down_now) begin
					lstate_d = plm_pkg::LS_DOWN;
				end
			end
			default: begin
				if (down_now) begin
					lstate_d = plm_pkg::LS_DOWN;
				end else if (pme_turnoff_ack) begin
					lstate_d = plm_pkg::LS_L23;
				end else if (ltssm_state == plm_pkg::LT_L0S) begin
					lstate_d = plm_pkg::LS_L0S;
				end else if (ltssm_state == plm_pkg::LT_L1) begin
					lstate_d = plm_pkg::LS_L1;
				end else begin
					lstate_d = plm_pkg::LS_L0;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			lstate_q <= plm_pkg::LS_DOWN;
			tlp_block_q <= 1'b1;
		end else begin
			lstate_q <= lstate_d;
			tlp_block_q <= lstate_d == plm_pkg::LS_L23 ||
				lstate_d == plm_pkg::LS_DOWN;
		end
	end

	// RULE_05 width in status register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (!reg_rd) begin
			reg_rdata_q <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				plm_pkg::REG_SWITCH_CTRL: reg_rdata_q <= 32'(unlock_q);
				plm_pkg::REG_LINK_CAP: reg_rdata_q <= 32'(maxw_q);
				plm_pkg::REG_LINK_STATUS:
					reg_rdata_q <= 32'(width_q) << plm_pkg::LW_LSB;
				plm_pkg::REG_DEV_CAP:
					reg_rdata_q <= (32'(cap_q.scale) << plm_pkg::SCALE_LSB) |
						(32'(cap_q.value) << plm_pkg::VALUE_LSB);
				plm_pkg::REG_SLOT_CAP: reg_rdata_q <= slot_cap_q;
				plm_pkg::REG_PM_CTRL: reg_rdata_q <= 32'(dstate_q);
				default: reg_rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	chk_maxw_locked: assert property ( // RULE_06
		@(posedge core_clk) disable iff (srst)
		wr_maxw && !unlock_q |=> $stable(maxw_q))
		else $error("max width changed while locked");
	chk_retrain_lock: assert property ( // RULE_13
		@(posedge core_clk) disable iff (srst)
		wr_retrain && IS_UPSTREAM && !unlock_q |=> !retrain_q)
		else $error("upstream retrain taken while locked");
	chk_retrain_dn: assert property ( // RULE_14
		@(posedge core_clk) disable iff (srst)
		wr_retrain && !IS_UPSTREAM |=> retrain_q)
		else $error("downstream retrain lost");
	chk_down_discard: assert property ( // RULE_15
		@(posedge core_clk) disable iff (srst)
		went_down |=> discard_q && ur_mode_q)
		else $error("link down not handled");
	chk_credit_adv: assert property ( // RULE_17
		@(posedge core_clk) disable iff (srst)
		went_up |=> fc_adv_q && fc_hdr_q == FC_HDR_CREDITS)
		else $error("credits not advertised");
	chk_spl_up: assert property ( // RULE_20
		@(posedge core_clk) disable iff (srst)
		went_up && !IS_UPSTREAM |=> spl_send_q)
		else $error("slot power message missing on link up");
	chk_spl_capture: assert property ( // RULE_18
		@(posedge core_clk) disable iff (srst)
		IS_UPSTREAM && spl_rx_valid |=> cap_q == $past(spl_rx))
		else $error("slot power fields not captured");
	chk_l23_block: assert property ( // RULE_21
		@(posedge core_clk) disable iff (srst)
		lstate_q == plm_pkg::LS_L23 |-> tlp_block_q &&
		($past(pme_turnoff_ack) || $past(lstate_q) == plm_pkg::LS_L23))
		else $error("L2/L3 ready entered or left open wrongly");
	chk_d3_l1: assert property ( // RULE_22
		@(posedge core_clk) disable iff (srst)
		dstate_q == plm_pkg::D3HOT && !down_now &&
		lstate_q != plm_pkg::LS_L23 |=> l1_req_q)
		else $error("D3hot did not request L1");
	chk_width_rd: assert property ( // RULE_05
		@(posedge core_clk) disable iff (srst)
		reg_rd && reg_addr == plm_pkg::REG_LINK_STATUS |=>
		reg_rdata_q[plm_pkg::LW_LSB +: 6] == $past(width_q))
		else $error("status width mismatch");
endmodule : plm_port
`default_nettype wire

// [core/plm_width_ctl.sv]
`default_nettype none
module plm_width_ctl (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic merged,
	input wire logic port_en,
	input wire logic train_start,
	input wire logic train_done,
	input wire logic [3:0] partner_width,
	input wire logic rev_detect,
	input wire logic [5:0] maxw_field,
	output logic [5:0] width_q,
	output logic [7:0] lane_pd_q,
	output logic [7:0] lane_l1_q,
	output logic [7:0][2:0] lane_map_q
);
	logic [5:0] maxw_lat_q;
	logic [5:0] width_d;
	logic [7:0] own;
	logic [7:0] used;
	logic [7:0][2:0] map_d;

	function automatic logic [5:0] pick_width(input logic [5:0] lim);
		if (lim >= 6'h08) begin
			pick_width = 6'h08;
		end else if (lim >= 6'h04) begin
			pick_width = 6'h04;
		end else if (lim >= 6'h02) begin
			pick_width = 6'h02;
		end else begin
			pick_width = 6'h01;
		end
	endfunction : pick_width

	// RULE_08 max width sampled at training
	always_ff @(posedge core_clk) begin
		if (srst) begin
			maxw_lat_q <= plm_pkg::MAXW_RST_X4;
		end else if (train_start) begin
			maxw_lat_q <= maxw_field;
		end
	end

	// RULE_04 widths 8/4/2/1 under caps
	always_comb begin
		width_d = merged ? 6'h08 : 6'h04;
		if (maxw_lat_q < width_d) begin
			width_d = maxw_lat_q;
		end
		if ({2'b00, partner_width} < width_d) begin
			width_d = {2'b00, partner_width};
		end
		width_d = pick_width(width_d);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			width_q <= 6'h00;
		end else if (train_done) begin
			width_q <= width_d;
		end
	end

	assign own = merged ? 8'hFF : 8'h0F;
	assign used = 8'((9'h001 << width_q[3:0]) - 9'h001);

	// RULE_09 RULE_10 RULE_11 lane power
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lane_pd_q <= 8'h00;
			lane_l1_q <= 8'h00;
		end else if (!port_en) begin
			lane_pd_q <= own;
			lane_l1_q <= 8'h00;
		end else if (merged && width_q != 6'h08 && width_q != 6'h00) begin
			lane_pd_q <= 8'hF0;
			lane_l1_q <= 8'h0F & ~used;
		end else if (width_q != 6'h00) begin
			lane_pd_q <= 8'h00;
			lane_l1_q <= own & ~used;
		end else begin
			lane_pd_q <= 8'h00;
			lane_l1_q <= 8'h00;
		end
	end

	// RULE_12 reversal over max width
	always_comb begin
		for (int p = 0; p < plm_pkg::LANES; p++) begin
			map_d[p] = 3'(p);
			if (rev_detect && 6'(p) < maxw_lat_q) begin
				map_d[p] = 3'(maxw_lat_q - 6'(p) - 6'h01);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int p = 0; p < plm_pkg::LANES; p++) begin
				lane_map_q[p] <= 3'(p);
			end
		end else if (train_done) begin
			lane_map_q <= map_d;
		end
	end
endmodule : plm_width_ctl
`default_nettype wire

// [dv/plm_link_partner.sv]
`default_nettype none
module plm_link_partner (
	input wire logic core_clk,
	input wire logic send_ts,
	input wire logic [7:0] inv_mask,
	output plm_pkg::plm_rx_sym_t [7:0] lane_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q = 1'b0;
	logic [4:0] idx_q = 5'h00;
	logic [7:0] idle_q = 8'h3C;
	// Idle pattern moves every cycle so stale data never looks valid
	always @(posedge core_clk) begin
		idle_q <= idle_q + 8'h35;
		if (busy_q) begin
			busy_q <= (idx_q != 5'h0F);
			idx_q <= idx_q + 5'h01;
		end else if (send_ts) begin
			busy_q <= 1'b1;
			idx_q <= 5'h00;
		end
	end
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			lane_rx[k].ts_valid = busy_q;
			lane_rx[k].idx = idx_q;
			lane_rx[k].sym = idle_q ^ 8'(k);
			if (busy_q)
				lane_rx[k].sym = (idx_q > 5'h05) ? 8'h4A : 8'hBC;
			if (busy_q && inv_mask[k])
				lane_rx[k].sym = ~lane_rx[k].sym;
		end
	end
endmodule : plm_link_partner
`default_nettype wire

// [dv/test_pcie_port_link_management.sv]
`default_nettype none
module test_pcie_port_link_management;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	plm_pkg::plm_ltssm_t ltssm_state = plm_pkg::LT_DETECT;
	logic merged = 1'b0;
	logic port_en = 1'b1;
	logic [3:0] partner_width = 4'h4;
	logic rev_detect = 1'b0;
	logic [7:0] tx_data_in = 8'h00;
	logic aspm_l1_req = 1'b0;
	logic pme_turnoff_ack = 1'b0;
	logic spl_rx_valid = 1'b0;
	plm_pkg::plm_spl_t spl_rx = 10'h000;
	logic send_ts = 1'b0;
	logic [7:0] inv_mask = 8'h00;
	plm_pkg::plm_rx_sym_t [7:0] lane_rx;
	logic [31:0] reg_rdata_q;
	logic [7:0] rx_inv_q, tx_data_q, lane_pd_q, lane_l1_q, fc_hdr_q;
	logic [7:0][7:0] rx_data_q;
	logic [5:0] width_q;
	logic [7:0][2:0] lane_map_q;
	logic [11:0] fc_data_q;
	logic retrain_q, link_up_q, discard_q, ur_mode_q, bridge_cfg_ok_q;
	logic fc_adv_q, spl_send_q, l1_req_q, tlp_block_q;
	plm_pkg::plm_lstate_t lstate_q;
	plm_pkg::plm_spl_t spl_tx_q;
	logic [31:0] up_rdata;
	logic up_retrain, up_cfg_ok;
	int fails = 0;
	int check_count = 0;

	plm_port #(.IS_UPSTREAM(1'b0)) i_dut (
		.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_q, .ltssm_state, .merged, .port_en, .partner_width,
		.rev_detect, .lane_rx, .tx_data_in, .aspm_l1_req, .pme_turnoff_ack,
		.spl_rx_valid, .spl_rx, .rx_inv_q, .rx_data_q, .tx_data_q, .width_q,
		.lane_pd_q, .lane_l1_q, .lane_map_q, .retrain_q, .link_up_q,
		.lstate_q, .discard_q, .ur_mode_q, .bridge_cfg_ok_q, .fc_adv_q,
		.fc_hdr_q, .fc_data_q, .spl_send_q, .spl_tx_q, .l1_req_q, .tlp_block_q
	);
	plm_port #(.IS_UPSTREAM(1'b1)) i_dut_up (
		.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_q(up_rdata), .ltssm_state, .merged, .port_en,
		.partner_width, .rev_detect, .lane_rx, .tx_data_in, .aspm_l1_req,
		.pme_turnoff_ack, .spl_rx_valid, .spl_rx, .rx_inv_q(), .rx_data_q(),
		.tx_data_q(), .width_q(), .lane_pd_q(), .lane_l1_q(), .lane_map_q(),
		.retrain_q(up_retrain), .link_up_q(), .lstate_q(), .discard_q(),
		.ur_mode_q(), .bridge_cfg_ok_q(up_cfg_ok), .fc_adv_q(), .fc_hdr_q(),
		.fc_data_q(), .spl_send_q(), .spl_tx_q(), .l1_req_q(), .tlp_block_q()
	);
	plm_link_partner i_partner (.core_clk, .send_ts, .inv_mask, .lane_rx);

	always #20 core_clk = ~core_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic go(input plm_pkg::plm_ltssm_t s);
		@(posedge core_clk);
		ltssm_state <= s;
		#1;
	endtask : go

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rdv(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata_q, e);
	endtask : rdv

	task automatic train(input logic [3:0] pw, input logic rv);
		@(posedge core_clk);
		ltssm_state <= plm_pkg::LT_CONFIG;
		partner_width <= pw;
		rev_detect <= rv;
		cyc(2);
		go(plm_pkg::LT_L0);
		cyc(4);
	endtask : train

	task automatic wait_l1(input logic v);
		int n;
		n = 0;
		while (l1_req_q !== v && n < 8) begin
			cyc(1);
			n++;
		end
		chk(l1_req_q, v);
	endtask : wait_l1

	task automatic t_reset();
		chk({ur_mode_q, tlp_block_q, link_up_q}, 3'h6);
		rdv(plm_pkg::REG_LINK_CAP, 32'h4);
		rdv(plm_pkg::REG_LINK_STATUS, 32'h0);
		rdv(8'hFC, 32'h0);
		rdv(plm_pkg::REG_LINK_CTRL, 32'h0);
	endtask : t_reset

	task automatic t_pol();
		logic [15:0] s;
		go(plm_pkg::LT_CONFIG);
		@(posedge core_clk);
		inv_mask <= 8'hA5;
		send_ts <= 1'b1;
		@(posedge core_clk);
		send_ts <= 1'b0;
		cyc(20);
		chk(rx_inv_q, 8'hA5);
		go(plm_pkg::LT_L0);
		cyc(3);
		chk(rx_inv_q, 8'hA5);
		@(posedge core_clk);
		tx_data_in <= 8'h5A;
		#1;
		s = {lane_rx[1].sym, lane_rx[0].sym};
		cyc(1);
		chk(tx_data_q, 8'h5A);
		chk({rx_data_q[1], rx_data_q[0]}, s ^ 16'h00FF);
		go(plm_pkg::LT_DETECT);
		cyc(2);
		chk(rx_inv_q, 8'h00);
	endtask : t_pol

	task automatic t_width();
		wr(plm_pkg::REG_LINK_CAP, 32'h2);
		rdv(plm_pkg::REG_LINK_CAP, 32'h4);
		wr(plm_pkg::REG_SWITCH_CTRL, 32'h1);
		train(4'h4, 1'b0);
		chk(width_q, 6'h04);
		rdv(plm_pkg::REG_LINK_STATUS, 32'h40);
		wr(plm_pkg::REG_LINK_CAP, 32'h2);
		rdv(plm_pkg::REG_LINK_CAP, 32'h2);
		cyc(3);
		chk(width_q, 6'h04);
		train(4'h4, 1'b1);
		chk(width_q, 6'h02);
		chk({lane_pd_q[3:0], lane_l1_q[3:0]}, 8'h0C);
		chk({lane_map_q[2], lane_map_q[1], lane_map_q[0]}, 9'h081);
		wr(plm_pkg::REG_LINK_CAP, 32'h4);
		train(4'h8, 1'b1);
		chk({width_q, lane_map_q[3], lane_map_q[0]}, 12'h103);
		train(4'h1, 1'b0);
		chk({width_q, lane_l1_q[3:0]}, 10'h01E);
	endtask : t_width

	task automatic t_merged();
		logic [3:0] pw[4] = '{4'h8, 4'h5, 4'h3, 4'h1};
		logic [3:0] w[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
		logic [7:0] l1;
		@(posedge core_clk);
		merged <= 1'b1;
		wr(plm_pkg::REG_LINK_CAP, 32'h8);
		foreach (pw[i]) begin
			train(pw[i], 1'b0);
			l1 = 8'h0F & ~((8'h01 << w[i]) - 8'h01);
			chk(width_q, {2'h0, w[i]});
			chk(lane_pd_q, (w[i] == 4'h8) ? 8'h00 : 8'hF0);
			chk(lane_l1_q, l1);
		end
		@(posedge core_clk);
		port_en <= 1'b0;
		cyc(3);
		chk(lane_pd_q, 8'hFF);
		@(posedge core_clk);
		merged <= 1'b0;
		cyc(3);
		chk(lane_pd_q, 8'h0F);
		@(posedge core_clk);
		port_en <= 1'b1;
		go(plm_pkg::LT_DETECT);
		cyc(3);
	endtask : t_merged

	task automatic t_links();
		plm_pkg::plm_ltssm_t dn[6] = '{plm_pkg::LT_DETECT,
			plm_pkg::LT_POLLING, plm_pkg::LT_CONFIG, plm_pkg::LT_DISABLED,
			plm_pkg::LT_LOOPBACK, plm_pkg::LT_HOTRESET};
		foreach (dn[i]) begin
			go(plm_pkg::LT_L0);
			cyc(1);
			chk({link_up_q, fc_adv_q, spl_send_q, ur_mode_q, discard_q,
				tlp_block_q}, 6'h38);
			chk({fc_hdr_q, fc_data_q}, 20'h10080);
			chk(lstate_q, plm_pkg::LS_L0);
			go(dn[i]);
			cyc(1);
			chk({link_up_q, discard_q, ur_mode_q, bridge_cfg_ok_q,
				tlp_block_q}, 5'h0F);
		end
		rdv(plm_pkg::REG_LINK_CAP, 32'h8);
		go(plm_pkg::LT_L0);
		go(plm_pkg::LT_L1);
		cyc(1);
		chk({link_up_q, 5'(lstate_q)}, 6'h22);
	endtask : t_links

	task automatic t_slot();
		go(plm_pkg::LT_L0);
		cyc(2);
		wr(plm_pkg::REG_SLOT_CAP, 32'h0A9C_0000);
		chk({spl_send_q, spl_tx_q}, {1'b1, 8'hA7, 2'h2});
		cyc(1);
		chk(spl_send_q, 1'b0);
		rdv(plm_pkg::REG_SLOT_CAP, 32'h0A9C_0000);
		go(plm_pkg::LT_DETECT);
		wr(plm_pkg::REG_SLOT_CAP, 32'h0400_0000);
		chk(spl_send_q, 1'b0);
	endtask : t_slot

	task automatic t_retrain();
		wr(plm_pkg::REG_SWITCH_CTRL, 32'h0);
		wr(plm_pkg::REG_LINK_CTRL, 32'h20);
		chk(retrain_q, 1'b1);
		cyc(1);
		chk(retrain_q, 1'b0);
		wr(plm_pkg::REG_LINK_CTRL, 32'h0);
		chk(retrain_q, 1'b0);
	endtask : t_retrain

	task automatic t_up();
		wr(plm_pkg::REG_LINK_CTRL, 32'h20);
		chk(up_retrain, 1'b0);
		wr(plm_pkg::REG_SWITCH_CTRL, 32'h1);
		wr(plm_pkg::REG_LINK_CTRL, 32'h20);
		chk(up_retrain, 1'b1);
		@(posedge core_clk);
		spl_rx <= {8'hC3, 2'h1};
		spl_rx_valid <= 1'b1;
		@(posedge core_clk);
		spl_rx_valid <= 1'b0;
		rdv(plm_pkg::REG_DEV_CAP, 32'h0);
		chk(up_rdata, 32'h070C_0000);
		chk(up_cfg_ok, 1'b0);
	endtask : t_up

	task automatic t_pm();
		go(plm_pkg::LT_L0);
		cyc(2);
		@(posedge core_clk);
		aspm_l1_req <= 1'b1;
		wait_l1(1'b1);
		@(posedge core_clk);
		aspm_l1_req <= 1'b0;
		wait_l1(1'b0);
		wr(plm_pkg::REG_PM_CTRL, 32'h3);
		wait_l1(1'b1);
		wr(plm_pkg::REG_PM_CTRL, 32'h0);
		wait_l1(1'b0);
		@(posedge core_clk);
		pme_turnoff_ack <= 1'b1;
		@(posedge core_clk);
		pme_turnoff_ack <= 1'b0;
		#1;
		chk({tlp_block_q, 5'(lstate_q)}, 6'h26);
		go(plm_pkg::LT_DETECT);
		cyc(1);
		chk(lstate_q, plm_pkg::LS_DOWN);
	endtask : t_pm

	task automatic results();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	initial begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		cyc(1);
		t_reset();
		t_pol();
		t_width();
		t_merged();
		t_links();
		t_slot();
		t_retrain();
		t_up();
		t_pm();
		results();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		results();
	end
endmodule : test_pcie_port_link_management
`default_nettype wire
